// [src/serial_port_pkg.sv]
// package: register map, field positions, reset values and carriers of the serial port glue
package serial_port_pkg;

  // ==========================================================
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00; // interrupt enables
  localparam logic [7:0] OFS_CONTROL_THREE = 8'h04; // routing and wake control
  localparam logic [7:0] OFS_FLAGS = 8'h08; // live serial flags, read only
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h0C; // sticky events, cleared by read
  localparam logic [7:0] OFS_EVENT_MASK = 8'h10; // event interrupt mask

  // ==========================================================
  // serial_control_two field positions
  localparam int TX_EMPTY_IE_BIT = 7; // tx_empty_irq_enable
  localparam int TX_DONE_IE_BIT = 6; // tx_done_irq_enable
  localparam int RX_FULL_IE_BIT = 5; // rx_full_irq_enable
  localparam int IDLE_IE_BIT = 4; // idle_irq_enable

  // serial_control_three field positions
  localparam int LOOPBACK_BIT = 0; // loopback_select
  localparam int RX_SOURCE_BIT = 1; // receiver_source_select
  localparam int DIRECTION_BIT = 2; // single_wire_direction
  localparam int EDGE_WAKE_BIT = 3; // rx_edge_wake_enable

  // flags and event positions share one layout
  localparam int IDLE_BIT = 0; // idle line
  localparam int RX_FULL_BIT = 1; // receive buffer full
  localparam int TX_DONE_BIT = 2; // transmission complete
  localparam int TX_EMPTY_BIT = 3; // transmit buffer empty
  localparam int RX_EDGE_BIT = 4; // active edge on receive input (events only)

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00; // all interrupts off
  localparam logic [3:0] CONTROL_THREE_RESET = 4'h0; // normal full duplex
  localparam logic [4:0] EVENT_STATUS_RESET = 5'h00; // no events
  localparam logic [4:0] EVENT_MASK_RESET = 5'h00; // all events masked

  // ==========================================================
  // halt states reported by the power controller
  typedef enum logic [1:0] {
    HALT_RUN,
    HALT_SHALLOW, // shallow_halt_state: registers kept
    HALT_MIDDLE, // middle_halt_state: registers lost
    HALT_DEEPEST // deepest_halt_state: registers lost
  } halt_e;

  // apb request from the bus master
  typedef struct packed {
    logic psel; // slave selected
    logic penable; // access phase
    logic pwrite; // write direction
    logic [7:0] paddr; // byte address
    logic [31:0] pwdata; // write data
  } apb_req_s;

  // apb answer back to the master
  typedef struct packed {
    logic pready; // transfer done
    logic pslverr; // unmapped address
    logic [31:0] prdata; // read data
  } apb_rsp_s;

  // live flags from the serial core
  typedef struct packed {
    logic tx_empty; // transmit buffer empty
    logic tx_done; // transmission complete
    logic rx_full; // receive buffer full
    logic idle; // idle line
  } serial_flags_s;

endpackage

// [src/serial_port_glue.sv]
// module: serial port interrupt enables, halt handling and line routing behind apb
// ==========================================================
// What this block does
// [R1] bit 7 enables tx empty interrupt
// [R2] bit 6 enables transmission complete interrupt
// [R3] bit 5 enables receive full interrupt
// [R4] bit 4 enables idle line interrupt
// [R5] control two readable and writable any time; in middle and deepest halt a write is lost to the reset value
// [R6] serial clocks stop in every halt state
// [R7] deep halts lose registers, shallow keeps them
// [R8] rx edge detect only in shallow halt; wakes
// [R9] after shallow halt serial resumes where stopped
// [R10] software avoids halting mid character
// [R11] loopback on: source picks loop or single wire
// [R12] loop mode: tx feeds rx, rx pin released
// [R13] single wire: rx from tx and pin
// [R14] single wire direction 0: pin is input
// [R15] single wire direction 1: transmitter drives pin
// [R16] single wire: receiver hears own transmissions
// [R17] loopback off: separate full duplex pins
// [R18] irq is or of enabled flags
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module serial_port_glue
(
  input wire logic clock, // bus clock, 250 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire serial_port_pkg::apb_req_s apb_req, // apb request
  output serial_port_pkg::apb_rsp_s apb_rsp, // apb answer
  input wire serial_port_pkg::halt_e halt_state, // power state, same clock
  input wire serial_port_pkg::serial_flags_s flags, // flags from serial core
  input wire logic tx_serial, // transmitter output bit
  output logic rx_serial, // receiver input bit
  output logic serial_clock_enable, // clock gate for the serial core
  input wire logic rx_pin_in, // receive pin, asynchronous
  output logic rx_pin_owned, // high while the receive pin serves the port
  input wire logic tx_pin_in, // transmit pin level, asynchronous
  output logic tx_pin_out, // transmit pin drive value
  output logic tx_pin_oe, // transmit pin output enable
  output logic serial_irq, // enabled flag interrupt, level
  output logic event_irq, // unmasked sticky event interrupt, level
  output logic wake_request // one-cycle wake pulse to the cpu
);

  // ==========================================================
  // state of the whole block
  typedef struct packed {
    logic [7:0] control_two; // interrupt enables plus spare bits
    logic [3:0] control_three; // routing and wake control
    logic [4:0] event_status; // sticky events
    logic [4:0] event_mask; // event mask
    logic [1:0] rx_sync; // receive pin synchroniser
    logic [1:0] tx_sync; // transmit pin synchroniser
    logic rx_prev; // previous synced receive level
    logic [3:0] flags_prev; // flags one cycle ago
    logic pready; // apb ready
    logic pslverr; // apb error
    logic [31:0] prdata; // apb read data
    logic rx_serial; // routed receiver input
    logic tx_out; // pin drive value
    logic tx_oe; // pin drive enable
    logic rx_owned; // receive pin in use
    logic clk_en; // serial clock gate
    logic serial_irq; // flag interrupt
    logic event_irq; // event interrupt
    logic wake; // wake pulse
  } glue_s;

  glue_s state_ff; // registered state
  glue_s nxt_state; // next state

  // ==========================================================
  // address decode used by the error answer; the read mux decodes by its own case
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == serial_port_pkg::OFS_CONTROL_TWO) ||
                (addr == serial_port_pkg::OFS_CONTROL_THREE) ||
                (addr == serial_port_pkg::OFS_FLAGS) ||
                (addr == serial_port_pkg::OFS_EVENT_STATUS) ||
                (addr == serial_port_pkg::OFS_EVENT_MASK);
  endfunction

  // flags packed in the shared layout
  logic [3:0] flag_vec; // current flags
  assign flag_vec = {flags.tx_empty, flags.tx_done, flags.rx_full, flags.idle};

  // enables packed in the same layout as flags
  function automatic logic [3:0] enable_vec(input logic [7:0] c2);
    enable_vec = {c2[serial_port_pkg::TX_EMPTY_IE_BIT], c2[serial_port_pkg::TX_DONE_IE_BIT],
                  c2[serial_port_pkg::RX_FULL_IE_BIT], c2[serial_port_pkg::IDLE_IE_BIT]};
  endfunction

  // ==========================================================
  // next state logic
  always_comb
  begin
    logic setup; // apb setup cycle
    logic done; // apb transfer completes this edge
    logic halted; // any halt state
    logic lost; // register contents lost
    logic edge_live; // edge detector powered
    logic rx_fall; // active edge on receive input
    logic [4:0] events; // new events this cycle
    logic loop_sel; // loopback_select
    logic src_sel; // receiver_source_select
    logic dir_sel; // single_wire_direction
    logic [3:0] c3; // current control three, before this cycle's update
    logic [7:0] c2; // current control two, before this cycle's update
    setup = 1'b0;
    done = 1'b0;
    halted = 1'b0;
    lost = 1'b0;
    edge_live = 1'b0;
    rx_fall = 1'b0;
    events = 5'h00;
    loop_sel = 1'b0;
    src_sel = 1'b0;
    dir_sel = 1'b0;
    c3 = 4'h0;
    c2 = 8'h00;
    nxt_state = state_ff;

    // two flop synchronisers for the pins
    nxt_state.rx_sync = {state_ff.rx_sync[0], rx_pin_in};
    nxt_state.tx_sync = {state_ff.tx_sync[0], tx_pin_in};
    nxt_state.rx_prev = state_ff.rx_sync[1];
    nxt_state.flags_prev = flag_vec;

    halted = (halt_state != serial_port_pkg::HALT_RUN);
    lost = (halt_state == serial_port_pkg::HALT_MIDDLE) ||
           (halt_state == serial_port_pkg::HALT_DEEPEST);
    // edge detector stays alive in run and shallow halt only
    edge_live = (halt_state == serial_port_pkg::HALT_RUN) ||
                (halt_state == serial_port_pkg::HALT_SHALLOW); // [R8]
    rx_fall = edge_live && state_ff.rx_prev && !state_ff.rx_sync[1];

    // serial core clock is gated in every halt state
    nxt_state.clk_en = !halted; // [R6]

    // rising flags and the receive edge become events
    events[3:0] = flag_vec & ~state_ff.flags_prev;
    events[serial_port_pkg::RX_EDGE_BIT] = rx_fall;

    // apb handshake: ready one cycle after setup
    setup = apb_req.psel && !apb_req.penable;
    done = apb_req.psel && apb_req.penable && state_ff.pready;
    nxt_state.pready = setup;
    if (setup)
    begin
      // answer prepared during setup so pready and data arrive together
      nxt_state.pslverr = !is_mapped(apb_req.paddr);
      nxt_state.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        serial_port_pkg::OFS_CONTROL_TWO:
          nxt_state.prdata[7:0] = state_ff.control_two; // [R5]
        serial_port_pkg::OFS_CONTROL_THREE:
          nxt_state.prdata[3:0] = state_ff.control_three;
        serial_port_pkg::OFS_FLAGS:
          nxt_state.prdata[3:0] = flag_vec;
        serial_port_pkg::OFS_EVENT_STATUS:
          nxt_state.prdata[4:0] = state_ff.event_status | events;
        serial_port_pkg::OFS_EVENT_MASK:
          nxt_state.prdata[4:0] = state_ff.event_mask;
        default:
          nxt_state.prdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    else if (done)
    begin
      // answer withdrawn after the completing edge
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = 32'h0000_0000;
    end

    // sticky events, a new event beats a read clear
    nxt_state.event_status = state_ff.event_status | events;
    if (done && !apb_req.pwrite && (apb_req.paddr == serial_port_pkg::OFS_EVENT_STATUS))
    begin
      // read clears only bits already shown, events of this cycle survive
      nxt_state.event_status = events;
    end

    // register writes take effect on the completing edge, except in middle and deepest halt where the reset values win
    if (done && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        serial_port_pkg::OFS_CONTROL_TWO:
          nxt_state.control_two = apb_req.pwdata[7:0]; // [R5]
        serial_port_pkg::OFS_CONTROL_THREE:
          nxt_state.control_three = apb_req.pwdata[3:0];
        serial_port_pkg::OFS_EVENT_MASK:
          nxt_state.event_mask = apb_req.pwdata[4:0];
        default:
          nxt_state.control_two = nxt_state.control_two; // read only or unmapped
      endcase
    end

    // deep halts wipe every register; shallow halt leaves all untouched
    if (lost)
    begin
      nxt_state.control_two = serial_port_pkg::CONTROL_TWO_RESET; // [R7]
      nxt_state.control_three = serial_port_pkg::CONTROL_THREE_RESET; // [R7]
      nxt_state.event_status = serial_port_pkg::EVENT_STATUS_RESET; // [R7]
      nxt_state.event_mask = serial_port_pkg::EVENT_MASK_RESET; // [R7]
    end

    // routing follows the current control three
    c3 = state_ff.control_three;
    c2 = state_ff.control_two;
    loop_sel = c3[serial_port_pkg::LOOPBACK_BIT];
    src_sel = c3[serial_port_pkg::RX_SOURCE_BIT];
    dir_sel = c3[serial_port_pkg::DIRECTION_BIT];
    if (!loop_sel)
    begin
      // separate pins, full duplex
      nxt_state.rx_serial = state_ff.rx_sync[1]; // [R17]
      nxt_state.tx_out = tx_serial; // [R17]
      nxt_state.tx_oe = 1'b1; // [R17]
      nxt_state.rx_owned = 1'b1; // [R17]
    end
    else if (!src_sel)
    begin
      // internal loop, receive pin released by the port
      nxt_state.rx_serial = tx_serial; // [R11] [R12]
      nxt_state.tx_out = tx_serial;
      nxt_state.tx_oe = 1'b1;
      nxt_state.rx_owned = 1'b0; // [R12]
    end
    else if (dir_sel)
    begin
      // single wire, transmitting: pin driven, own data looped back
      nxt_state.rx_serial = tx_serial; // [R11] [R13] [R16]
      nxt_state.tx_out = tx_serial; // [R15]
      nxt_state.tx_oe = 1'b1; // [R15]
      nxt_state.rx_owned = 1'b0; // [R13]
    end
    else
    begin
      // single wire, listening: pin released to the remote device
      nxt_state.rx_serial = state_ff.tx_sync[1]; // [R13] [R14]
      nxt_state.tx_out = 1'b1;
      nxt_state.tx_oe = 1'b0; // [R14]
      nxt_state.rx_owned = 1'b0; // [R13]
    end

    // flag interrupt: each flag gated by its enable
    nxt_state.serial_irq = |(flag_vec & enable_vec(c2)); // [R1] [R2] [R3] [R4] [R18]
    nxt_state.event_irq = |(state_ff.event_status & state_ff.event_mask);

    // wake out of shallow halt on an active receive edge when enabled
    nxt_state.wake = rx_fall && (halt_state == serial_port_pkg::HALT_SHALLOW) &&
                     c3[serial_port_pkg::EDGE_WAKE_BIT]; // [R8]
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= '{control_two: serial_port_pkg::CONTROL_TWO_RESET,
                    control_three: serial_port_pkg::CONTROL_THREE_RESET,
                    event_status: serial_port_pkg::EVENT_STATUS_RESET,
                    event_mask: serial_port_pkg::EVENT_MASK_RESET,
                    rx_sync: 2'h3, tx_sync: 2'h3, rx_prev: 1'b1,
                    flags_prev: 4'h0, pready: 1'b0, pslverr: 1'b0,
                    prdata: 32'h0000_0000, rx_serial: 1'b1, tx_out: 1'b1,
                    tx_oe: 1'b1, rx_owned: 1'b1, clk_en: 1'b1,
                    serial_irq: 1'b0, event_irq: 1'b0, wake: 1'b0};
    end
    else
    begin
      // shallow halt holds nothing back here; the core resumes from its own frozen state
      state_ff <= nxt_state; // [R9]
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign apb_rsp.pready = state_ff.pready;
  assign apb_rsp.pslverr = state_ff.pslverr;
  assign apb_rsp.prdata = state_ff.prdata;
  assign rx_serial = state_ff.rx_serial;
  assign serial_clock_enable = state_ff.clk_en;
  assign rx_pin_owned = state_ff.rx_owned;
  assign tx_pin_out = state_ff.tx_out;
  assign tx_pin_oe = state_ff.tx_oe;
  assign serial_irq = state_ff.serial_irq;
  assign event_irq = state_ff.event_irq;
  assign wake_request = state_ff.wake;

  // ==========================================================
  // assertions
  default clocking main_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_TX_EMPTY_IRQ: assert property ( // [R1]
    (flags.tx_empty && state_ff.control_two[serial_port_pkg::TX_EMPTY_IE_BIT]) |=> serial_irq)
    else $error("tx empty enabled but no interrupt");
  AST_TX_DONE_IRQ: assert property ( // [R2]
    (flags.tx_done && state_ff.control_two[serial_port_pkg::TX_DONE_IE_BIT]) |=> serial_irq)
    else $error("tx done enabled but no interrupt");
  AST_RX_FULL_IRQ: assert property ( // [R3]
    (flags.rx_full && state_ff.control_two[serial_port_pkg::RX_FULL_IE_BIT]) |=> serial_irq)
    else $error("rx full enabled but no interrupt");
  AST_IRQ_GATED: assert property ( // [R4] [R18]
    ((flag_vec & enable_vec(state_ff.control_two)) == 4'h0) |=> !serial_irq)
    else $error("interrupt without enabled flag");
  AST_WRITE_C2: assert property ( // [R5]
    (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
     apb_req.paddr == serial_port_pkg::OFS_CONTROL_TWO && halt_state == serial_port_pkg::HALT_RUN)
    |=> state_ff.control_two == $past(apb_req.pwdata[7:0]))
    else $error("control two write lost");
  AST_CLOCK_STOP: assert property ( // [R6]
    (halt_state != serial_port_pkg::HALT_RUN) |=> !serial_clock_enable)
    else $error("serial clock running in halt");
  AST_DEEP_LOSS: assert property ( // [R7]
    (halt_state == serial_port_pkg::HALT_MIDDLE) |=> state_ff.control_two == 8'h00)
    else $error("register kept through middle halt");
  AST_SHALLOW_KEEP: assert property ( // [R7]
    (halt_state == serial_port_pkg::HALT_SHALLOW && !apb_req.psel)
    |=> $stable(state_ff.control_two))
    else $error("register changed in shallow halt");
  AST_NO_WAKE_MIDDLE: assert property ( // [R8]
    (halt_state == serial_port_pkg::HALT_MIDDLE) |=> !wake_request)
    else $error("wake from middle halt");
  AST_WAKE_GATED: assert property ( // [R8]
    !state_ff.control_three[serial_port_pkg::EDGE_WAKE_BIT] |=> !wake_request)
    else $error("wake with edge wake disabled");
  AST_LISTEN: assert property ( // [R14]
    (state_ff.control_three[2:0] == 3'h3) |=> !tx_pin_oe)
    else $error("pin driven while listening");
  AST_LOOP_ECHO: assert property ( // [R12] [R16]
    (state_ff.control_three[serial_port_pkg::LOOPBACK_BIT] &&
     (!state_ff.control_three[serial_port_pkg::RX_SOURCE_BIT] ||
      state_ff.control_three[serial_port_pkg::DIRECTION_BIT]))
    |=> (rx_serial == $past(tx_serial)) && !rx_pin_owned)
    else $error("loop path broken");

  COV_SINGLE_WIRE_TX: cover property (state_ff.control_three[2:0] == 3'h7 && tx_pin_oe);
  COV_WAKE: cover property (wake_request);
  COV_STATUS_READ: cover property (apb_req.psel && apb_req.penable && apb_rsp.pready &&
    !apb_req.pwrite && apb_req.paddr == serial_port_pkg::OFS_EVENT_STATUS);

endmodule

// [sim/serial_remote_model.sv]
// model: remote serial device sitting on the receive and transmit pins
`timescale 1ns/1ps

module serial_remote_model
(
  input wire logic send_level, // level the remote puts on its line
  input wire logic pin_oe, // port drives the shared transmit pin
  input wire logic pin_out, // port drive value on the transmit pin
  output logic rx_line, // receive pin level seen by the port
  output logic tx_line // resolved transmit pin level
);
  // ==========================================================
  // line drivers
  // remote always drives its own line onto the receive pin
  assign rx_line = send_level;
  // remote drives the shared pin only while the port listens, never against it
  assign tx_line = pin_oe ? pin_out : send_level;
endmodule

// [sim/tb_serial_port_glue.sv]
// testbench: registers, interrupts, halt handling and line routing of the serial glue
`timescale 1ns/1ps

module tb_serial_port_glue;
  // ==========================================================
  // signals
  logic clock = 1'b0; // bus clock
  logic resetn = 1'b0; // reset, active low
  serial_port_pkg::apb_req_s apb_req = '0; // bus request
  serial_port_pkg::apb_rsp_s apb_rsp; // bus answer
  serial_port_pkg::halt_e halt_state = serial_port_pkg::HALT_RUN; // power state
  serial_port_pkg::serial_flags_s flags = '0; // core flags
  logic tx_serial = 1'b1; // transmitter bit
  logic send_level = 1'b1; // remote line level
  logic rx_serial, serial_clock_enable, rx_pin_in, rx_pin_owned; // design outputs and the receive pin driven by the remote
  logic tx_pin_in, tx_pin_out, tx_pin_oe, serial_irq, event_irq, wake_request; // more outputs
  int fail_count = 0; // mismatches
  int checks_done = 0; // comparisons
  logic [31:0] rdata; // last read data
  logic err; // last error answer
  logic [7:0] val; // random enable byte
  logic [3:0] fl; // random flags
  logic seen; // wake pulse observed
  logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h3, 3'h7}; // routing modes
  serial_port_pkg::halt_e deep [2] = '{serial_port_pkg::HALT_MIDDLE,
    serial_port_pkg::HALT_DEEPEST}; // halts that lose registers

  // 4 ns clock
  always #2 clock = ~clock;

  // ==========================================================
  // design and remote device
  serial_port_glue u_dut (.clock(clock), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .halt_state(halt_state), .flags(flags), .tx_serial(tx_serial), .rx_serial(rx_serial),
    .serial_clock_enable(serial_clock_enable), .rx_pin_in(rx_pin_in),
    .rx_pin_owned(rx_pin_owned), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .serial_irq(serial_irq), .event_irq(event_irq),
    .wake_request(wake_request));
  serial_remote_model u_remote (.send_level(send_level), .pin_oe(tx_pin_oe),
    .pin_out(tx_pin_out), .rx_line(rx_pin_in), .tx_line(tx_pin_in));

  // ==========================================================
  // reporting
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // single bit compare
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %b seen %b", name, exp, got);
      fail_count++;
    end
  endtask

  // word compare
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // ==========================================================
  // bus and timing helpers
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clock);
      if (apb_rsp.pready === 1'b1)
        break;
    end
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    // hung bus ends the run
    if (n == 16)
    begin
      fail_count++;
      end_sim;
    end
  endtask

  // read a register and compare
  task automatic chk_reg(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk_word(name, exp, rdata);
  endtask

  // one cycle routing plus two synchroniser stages, with margin
  task automatic settle;
    repeat (6) @(posedge clock);
  endtask

  // look for a wake pulse in a bounded window
  task automatic watch_wake;
    seen = 1'b0;
    repeat (12)
    begin
      @(posedge clock);
      if (wake_request === 1'b1)
        seen = 1'b1;
    end
  endtask

  // ==========================================================
  // expectations
  // enabled flags ored together
  function automatic logic exp_irq(input logic [7:0] ctrl, input logic [3:0] f);
    return |(ctrl[7:4] & f);
  endfunction

  // {rx_serial, tx_pin_out, tx_pin_oe, rx_pin_owned} per routing mode
  function automatic logic [3:0] exp_route(input logic [2:0] m, input logic tx, input logic rem);
    if (!m[0])
      return {rem, tx, 1'b1, 1'b1};
    else if (!m[1])
      return {tx, tx, 1'b1, 1'b0};
    else if (!m[2])
      return {rem, 1'b1, 1'b0, 1'b0};
    return {tx, tx, 1'b1, 1'b0};
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(85909));
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    // reset values and register access
    chk_reg("control_two", serial_port_pkg::OFS_CONTROL_TWO, 32'h0);
    chk_reg("control_three", serial_port_pkg::OFS_CONTROL_THREE, 32'h0);
    chk_reg("event_mask", serial_port_pkg::OFS_EVENT_MASK, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk_bit("unmapped_err", 1'b1, err);
    chk_word("unmapped_data", 32'h0, rdata);
    apb(1'b1, serial_port_pkg::OFS_FLAGS, 32'hFF);
    chk_reg("flags", serial_port_pkg::OFS_FLAGS, 32'h0);
    // each enable against its own flag alone
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, serial_port_pkg::OFS_CONTROL_TWO, 32'h10 << i);
      flags <= serial_port_pkg::serial_flags_s'(~(4'h1 << i));
      settle;
      chk_bit("irq_other", 1'b0, serial_irq);
      flags <= serial_port_pkg::serial_flags_s'(4'h1 << i);
      settle;
      chk_bit("irq_own", 1'b1, serial_irq);
    end
    // random enables and flags, written while interrupts stand
    repeat (24)
    begin
      val = 8'($urandom);
      fl = 4'($urandom);
      apb(1'b1, serial_port_pkg::OFS_CONTROL_TWO, {24'h0, val});
      flags <= serial_port_pkg::serial_flags_s'(fl);
      settle;
      chk_bit("serial_irq", exp_irq(val, fl), serial_irq);
      chk_reg("control_two", serial_port_pkg::OFS_CONTROL_TWO, {24'h0, val});
    end
    // routing modes, transmitter and remote at opposite levels
    foreach (modes[m])
    begin
      apb(1'b1, serial_port_pkg::OFS_CONTROL_THREE, {29'h0, modes[m]});
      for (int b = 0; b < 2; b++)
      begin
        tx_serial <= b[0];
        send_level <= ~b[0];
        settle;
        chk_word("route", {28'h0, exp_route(modes[m], b[0], ~b[0])},
          {28'h0, rx_serial, tx_pin_out, tx_pin_oe, rx_pin_owned});
      end
    end
    tx_serial <= 1'b1;
    send_level <= 1'b1;
    apb(1'b1, serial_port_pkg::OFS_CONTROL_THREE, 32'h0);
    // sticky events, mask and clear on read
    flags <= '0;
    settle;
    apb(1'b0, serial_port_pkg::OFS_EVENT_STATUS, 32'h0);
    apb(1'b1, serial_port_pkg::OFS_EVENT_MASK, 32'h0F);
    flags.idle <= 1'b1;
    settle;
    chk_bit("event_irq", 1'b1, event_irq);
    chk_reg("event_status", serial_port_pkg::OFS_EVENT_STATUS, 32'h1);
    settle;
    chk_bit("event_irq_cleared", 1'b0, event_irq);
    apb(1'b1, serial_port_pkg::OFS_EVENT_MASK, 32'h0);
    flags.rx_full <= 1'b1;
    settle;
    chk_bit("event_irq_masked", 1'b0, event_irq);
    chk_reg("event_status", serial_port_pkg::OFS_EVENT_STATUS, 32'h2);
    // shallow halt with the line idle: state kept, edge wakes only when enabled
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, serial_port_pkg::OFS_CONTROL_TWO, 32'hA5);
      apb(1'b1, serial_port_pkg::OFS_CONTROL_THREE, {28'h0, e[0], 3'h0});
      settle;
      halt_state <= serial_port_pkg::HALT_SHALLOW;
      settle;
      chk_bit("clock_enable", 1'b0, serial_clock_enable);
      send_level <= 1'b0;
      watch_wake;
      chk_bit("wake_shallow", e[0], seen);
      send_level <= 1'b1;
      halt_state <= serial_port_pkg::HALT_RUN;
      settle;
      chk_bit("clock_enable", 1'b1, serial_clock_enable);
      chk_reg("control_two", serial_port_pkg::OFS_CONTROL_TWO, 32'hA5);
      chk_reg("control_three", serial_port_pkg::OFS_CONTROL_THREE, {28'h0, e[0], 3'h0});
    end
    // deeper halts lose all registers and ignore the edge
    foreach (deep[d])
    begin
      apb(1'b1, serial_port_pkg::OFS_CONTROL_TWO, 32'hA5);
      apb(1'b1, serial_port_pkg::OFS_CONTROL_THREE, 32'h8);
      halt_state <= deep[d];
      settle;
      chk_bit("clock_enable", 1'b0, serial_clock_enable);
      send_level <= 1'b0;
      watch_wake;
      chk_bit("wake_deep", 1'b0, seen);
      send_level <= 1'b1;
      halt_state <= serial_port_pkg::HALT_RUN;
      settle;
      chk_reg("control_two", serial_port_pkg::OFS_CONTROL_TWO, 32'h0);
      chk_reg("control_three", serial_port_pkg::OFS_CONTROL_THREE, 32'h0);
    end
    end_sim;
  end
endmodule
